// *** bpm_pkg.sv ***
/*
  Shared constants and types of the block protection bit mapper.
  Assumes a byte-addressed array whose size is 2^m 64-Kbyte blocks.
*/
package bpm_pkg;

  // Widths.
  localparam int ADDR_W = 24;
  localparam int EXT_W = 33;
  localparam int BIT_W = 9;
  localparam int M_W = 4;
  localparam int ADDR_W_MAX = 32;

  // Density limits.
  localparam logic [3:0] M_MIN = 4'h4;
  localparam logic [3:0] M_MAX = 4'h8;

  // Block sizes in bytes.
  localparam logic [32:0] SIZE_8K = 33'h000002000;
  localparam logic [32:0] SIZE_32K = 33'h000008000;
  localparam logic [32:0] SIZE_64K = 33'h000010000;

  // Address field positions.
  localparam int K_LSB = 13;
  localparam int K_MSB = 14;
  localparam int BLK64_LSB = 16;

  // Sector type codes and their size entry locations.
  localparam logic [7:0] TYPE_1 = 8'h01;
  localparam logic [7:0] TYPE_8K = 8'h02;
  localparam logic [7:0] TYPE_32K = 8'h03;
  localparam logic [7:0] TYPE_64K = 8'h04;
  localparam logic [7:0] TYPE_TAB_BASE = 8'h4C;

  // Sector count exponents.
  localparam logic [7:0] CNT_8K = 8'h02;
  localparam logic [7:0] CNT_32K = 8'h00;

  // Start and end adders.
  localparam logic [7:0] ADD_BOT_S = 8'hFF;
  localparam logic [7:0] ADD_BOT_E = 8'h06;
  localparam logic [7:0] ADD_LO32 = 8'hFD;
  localparam logic [7:0] ADD_MID_S = 8'h00;
  localparam logic [7:0] ADD_MID_E = 8'hFC;
  localparam logic [7:0] ADD_HI32 = 8'hFE;
  localparam logic [7:0] ADD_TOP_S = 8'h07;
  localparam logic [7:0] ADD_TOP_E = 8'h0E;

  typedef enum logic [2:0] {SEC_NONE, SEC_BOT8, SEC_LO32, SEC_MID64, SEC_HI32,
    SEC_TOP8} bpm_sec_t;

  typedef struct packed {
    logic [7:0] type_num;
    logic [7:0] count_field;
    logic [7:0] start_field;
    logic [7:0] end_field;
  } bpm_desc_t;

  typedef struct packed {
    bpm_sec_t sec;
    logic [8:0] wr_bit;
    logic [8:0] rd_bit;
    logic rd_ok;
    logic [8:0] start_bit;
    logic [8:0] end_bit;
    logic [8:0] count;
    logic [7:0] type_addr;
  } bpm_map_t;

endpackage

// *** bpm_mapper.sv ***
/*
  Block protection bit mapper: byte address and density in, section,
  parameter table descriptor and protection bit indices out, one clock later.
  Assumes addr, dens_m and sample come from logic on clk.
*/
// Functional notes
// - Layout: 4x8K, 32K, 64K run, 32K, 4x8K.
// - Middle run holds 2^m minus two blocks.
// - Density m is 4 to 8.
// - Types: 8K is 2, 32K 3, 64K 4.
// - Type code equals index; size entry located.
// - Small section count is two to n.
// - Field 00H is bit 0, else 2^m+1+c.
// - Bits rise by one across the section.
// - Middle run spans bit 0 to adder -4.
// - Lower 32K at -3, upper at -2.
// - Bottom 8K spans -1 to 6, odd read.
// - Top 8K spans 7 to 14, odd read.
// - Uniform 4K sectors are never described.
// - Recurring sizes form separate sections.
`timescale 1ns/1ns
module bpm_mapper #(
  parameter int ADDR_W = bpm_pkg::ADDR_W
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic nrst,
  // Request.
  input wire logic sample,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [3:0] dens_m,
  // Result.
  output logic out_valid,
  output logic out_err,
  output bpm_pkg::bpm_map_t map,
  output bpm_pkg::bpm_desc_t desc
);

  if (ADDR_W < bpm_pkg::ADDR_W || ADDR_W > bpm_pkg::ADDR_W_MAX) begin : g_chk
    $error("bpm_mapper: ADDR_W out of range");
  end

  // Turns a start or end field into a bit index.
  function automatic logic [8:0] field_to_bit(input logic [7:0] f, input logic [3:0] m);
    logic [9:0] sum;
    sum = 10'h000;
    if (f == 8'h00) begin
      field_to_bit = 9'h000;
    end else begin
      sum = 10'(10'h001 << m) + 10'h001 + {{2{f[7]}}, f};
      field_to_bit = sum[8:0];
    end
  endfunction

  // Turns a type and count field into a sector count.
  function automatic logic [8:0] field_to_count(input logic [7:0] t, input logic [7:0] f,
      input logic [3:0] m);
    if (t == bpm_pkg::TYPE_64K) begin
      field_to_count = 9'(9'h001 << m) - 9'h002;
    end else if (t == bpm_pkg::TYPE_8K || t == bpm_pkg::TYPE_32K) begin
      field_to_count = 9'(9'h001 << f[3:0]);
    end else begin
      field_to_count = 9'h000;
    end
  endfunction

  // Parameter table descriptor of a section.
  function automatic bpm_pkg::bpm_desc_t sec_desc(input bpm_pkg::bpm_sec_t s,
      input logic [3:0] m);
    sec_desc = '0;
    case (s)
      bpm_pkg::SEC_BOT8: begin
        sec_desc = {bpm_pkg::TYPE_8K, bpm_pkg::CNT_8K, bpm_pkg::ADD_BOT_S,
          bpm_pkg::ADD_BOT_E};
      end
      bpm_pkg::SEC_LO32: begin
        sec_desc = {bpm_pkg::TYPE_32K, bpm_pkg::CNT_32K, bpm_pkg::ADD_LO32,
          bpm_pkg::ADD_LO32};
      end
      bpm_pkg::SEC_MID64: begin
        sec_desc = {bpm_pkg::TYPE_64K, {4'h0, m}, bpm_pkg::ADD_MID_S,
          bpm_pkg::ADD_MID_E};
      end
      bpm_pkg::SEC_HI32: begin
        sec_desc = {bpm_pkg::TYPE_32K, bpm_pkg::CNT_32K, bpm_pkg::ADD_HI32,
          bpm_pkg::ADD_HI32};
      end
      bpm_pkg::SEC_TOP8: begin
        sec_desc = {bpm_pkg::TYPE_8K, bpm_pkg::CNT_8K, bpm_pkg::ADD_TOP_S,
          bpm_pkg::ADD_TOP_E};
      end
      default: begin
        sec_desc = '0;
      end
    endcase
  endfunction

  // Density check and section boundaries.
  wire m_ok = (dens_m >= bpm_pkg::M_MIN) && (dens_m <= bpm_pkg::M_MAX);
  wire [32:0] a_ext = 33'(addr);
  wire [32:0] arr_size = bpm_pkg::SIZE_64K << dens_m;
  wire [32:0] b_lo32 = bpm_pkg::SIZE_32K;
  wire [32:0] b_mid = bpm_pkg::SIZE_64K;
  wire [32:0] b_hi32 = arr_size - bpm_pkg::SIZE_64K;
  wire [32:0] b_top = arr_size - bpm_pkg::SIZE_32K;
  wire in_range = m_ok && (a_ext < arr_size);

  // Section select; only blocks with their own protection bits are described.
  wire bpm_pkg::bpm_sec_t sel_sec = !in_range ? bpm_pkg::SEC_NONE :
    (a_ext < b_lo32) ? bpm_pkg::SEC_BOT8 :
    (a_ext < b_mid) ? bpm_pkg::SEC_LO32 :
    (a_ext < b_hi32) ? bpm_pkg::SEC_MID64 :
    (a_ext < b_top) ? bpm_pkg::SEC_HI32 : bpm_pkg::SEC_TOP8;

  // Descriptor and decoded fields.
  wire bpm_pkg::bpm_desc_t sel_desc = sec_desc(sel_sec, dens_m);
  wire [8:0] sel_start = field_to_bit(sel_desc.start_field, dens_m);
  wire [8:0] sel_end = field_to_bit(sel_desc.end_field, dens_m);
  wire [8:0] sel_count = field_to_count(sel_desc.type_num, sel_desc.count_field, dens_m);
  wire [7:0] sel_type_addr = (sel_desc.type_num == 8'h00) ? 8'h00 :
    bpm_pkg::TYPE_TAB_BASE + 8'((sel_desc.type_num - bpm_pkg::TYPE_1) << 1);

  // Bit of the addressed block.
  wire is_8k = (sel_sec == bpm_pkg::SEC_BOT8) || (sel_sec == bpm_pkg::SEC_TOP8);
  wire [1:0] blk_k = addr[bpm_pkg::K_MSB:bpm_pkg::K_LSB];
  wire [8:0] blk64_idx = 9'(a_ext[32:bpm_pkg::BLK64_LSB]) - 9'h001;
  wire [8:0] sel_wr = is_8k ? sel_start + {6'h00, blk_k, 1'b0} :
    (sel_sec == bpm_pkg::SEC_MID64) ? sel_start + blk64_idx : sel_start;
  wire [8:0] sel_rd = is_8k ? sel_wr + 9'h001 : sel_wr;

  wire bpm_pkg::bpm_map_t sel_map = '{sec: sel_sec, wr_bit: sel_wr, rd_bit: sel_rd,
    rd_ok: is_8k, start_bit: sel_start, end_bit: sel_end, count: sel_count,
    type_addr: sel_type_addr};

  // Next values: load on sample, hold otherwise.
  wire next_valid = sample | out_valid;
  wire next_err = sample ? !in_range : out_err;
  wire bpm_pkg::bpm_map_t next_map = sample ? sel_map : map;
  wire bpm_pkg::bpm_desc_t next_desc = sample ? sel_desc : desc;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      out_valid <= 1'b0;
      out_err <= 1'b0;
      map <= '0;
      desc <= '0;
    end else begin
      out_valid <= next_valid;
      out_err <= next_err;
      map <= next_map;
      desc <= next_desc;
    end
  end

  // Checks.
  valid_after_sample_a: assert property (@(posedge clk) disable iff (!nrst)
    sample |=> out_valid && map == $past(sel_map))
    else $error("result not presented one clock after sample");

  invalid_until_sample_a: assert property (@(posedge clk) disable iff (!nrst)
    !out_valid && !sample |=> !out_valid)
    else $error("valid raised without a sample");

  bottom_order_a: assert property (@(posedge clk) disable iff (!nrst)
    sample && m_ok && a_ext < bpm_pkg::SIZE_32K |=> map.sec == bpm_pkg::SEC_BOT8)
    else $error("lowest 32K not mapped to bottom 8K section");

  mid_count_a: assert property (@(posedge clk) disable iff (!nrst)
    sample && sel_sec == bpm_pkg::SEC_MID64
    |=> map.count == 9'(9'h001 << $past(dens_m)) - 9'h002)
    else $error("middle block count wrong");

  bad_density_a: assert property (@(posedge clk) disable iff (!nrst)
    sample && !m_ok |=> out_err && map.sec == bpm_pkg::SEC_NONE)
    else $error("bad density not flagged");

  type_code_a: assert property (@(posedge clk) disable iff (!nrst)
    out_valid && map.rd_ok |-> desc.type_num == bpm_pkg::TYPE_8K &&
    map.type_addr == 8'h4E)
    else $error("8K section type wrong");

  zero_field_a: assert property (@(posedge clk) disable iff (!nrst)
    out_valid && !out_err && desc.start_field == 8'h00 |-> map.start_bit == 9'h000)
    else $error("zero start field not bit 0");

  span_width_a: assert property (@(posedge clk) disable iff (!nrst)
    out_valid && !out_err && map.sec != bpm_pkg::SEC_MID64 |->
    map.end_bit - map.start_bit + 9'h001 == (map.rd_ok ? 9'h008 : map.count))
    else $error("bit span does not match sector count");

  mid_span_a: assert property (@(posedge clk) disable iff (!nrst)
    sample && sel_sec == bpm_pkg::SEC_MID64 |=> map.start_bit == 9'h000 &&
    map.end_bit == 9'(9'h001 << $past(dens_m)) - 9'h003)
    else $error("middle section bit range wrong");

  lo32_bit_a: assert property (@(posedge clk) disable iff (!nrst)
    sample && sel_sec == bpm_pkg::SEC_LO32 |=> map.start_bit == map.end_bit &&
    map.wr_bit == 9'(9'h001 << $past(dens_m)) - 9'h002)
    else $error("lower 32K bit wrong");

  hi32_bit_a: assert property (@(posedge clk) disable iff (!nrst)
    sample && sel_sec == bpm_pkg::SEC_HI32 |=> map.start_bit == map.end_bit &&
    map.wr_bit == 9'(9'h001 << $past(dens_m)) - 9'h001)
    else $error("upper 32K bit wrong");

  bottom_bits_a: assert property (@(posedge clk) disable iff (!nrst)
    sample && sel_sec == bpm_pkg::SEC_BOT8 |=> map.start_bit ==
    9'(9'h001 << $past(dens_m)) && map.end_bit == map.start_bit + 9'h007)
    else $error("bottom 8K range wrong");

  top_bits_a: assert property (@(posedge clk) disable iff (!nrst)
    sample && sel_sec == bpm_pkg::SEC_TOP8 |=> map.start_bit ==
    9'(9'h001 << $past(dens_m)) + 9'h008 && map.end_bit == map.start_bit + 9'h007)
    else $error("top 8K range wrong");

  lock_pair_a: assert property (@(posedge clk) disable iff (!nrst)
    out_valid && map.rd_ok |-> !map.wr_bit[0] && map.rd_bit == map.wr_bit + 9'h001)
    else $error("8K write and read bits not paired");

  small_count_a: assert property (@(posedge clk) disable iff (!nrst)
    out_valid && map.sec == bpm_pkg::SEC_LO32 |-> map.count == 9'h001 &&
    desc.count_field == 8'h00)
    else $error("32K count wrong");

  err_clear_a: assert property (@(posedge clk) disable iff (!nrst)
    sample && in_range |=> !out_err && map.sec != bpm_pkg::SEC_NONE)
    else $error("good request flagged as error");

  hold_result_a: assert property (@(posedge clk) disable iff (!nrst)
    out_valid && !sample |=> $stable(map) && $stable(desc) && $stable(out_err))
    else $error("result changed without a sample");

  valid_stays_a: assert property (@(posedge clk) disable iff (!nrst)
    out_valid |=> out_valid)
    else $error("valid dropped without reset");

  err_zero_a: assert property (@(posedge clk) disable iff (!nrst)
    out_valid && out_err |-> map == '0 && desc == '0)
    else $error("refused request left fields set");

  mid_type_a: assert property (@(posedge clk) disable iff (!nrst)
    out_valid && map.sec == bpm_pkg::SEC_MID64 |-> desc.type_num == 8'h04 &&
    map.type_addr == 8'h52)
    else $error("64K section type wrong");

  type32_addr_a: assert property (@(posedge clk) disable iff (!nrst)
    out_valid && (map.sec == bpm_pkg::SEC_LO32 || map.sec == bpm_pkg::SEC_HI32)
    |-> desc.type_num == 8'h03 && map.type_addr == 8'h50)
    else $error("32K section type wrong");

  small8_count_a: assert property (@(posedge clk) disable iff (!nrst)
    out_valid && map.rd_ok |-> map.count == 9'h004 && desc.count_field == 8'h02)
    else $error("8K count wrong");

  mid_bit_range_a: assert property (@(posedge clk) disable iff (!nrst)
    out_valid && map.sec == bpm_pkg::SEC_MID64 |-> map.wr_bit <= map.end_bit &&
    map.rd_bit == map.wr_bit && !map.rd_ok)
    else $error("64K block bit outside its section");

  bit_in_span_a: assert property (@(posedge clk) disable iff (!nrst)
    out_valid && !out_err |-> map.wr_bit >= map.start_bit && map.rd_bit <= map.end_bit)
    else $error("block bit outside its section");

  mid_first_a: assert property (@(posedge clk) disable iff (!nrst)
    sample && m_ok && a_ext[32:16] == 17'h00001 |=> map.sec == bpm_pkg::SEC_MID64 &&
    map.wr_bit == 9'h000)
    else $error("first 64K block not at bit 0");

  mid_fields_a: assert property (@(posedge clk) disable iff (!nrst)
    out_valid && map.sec == bpm_pkg::SEC_MID64 |-> desc.start_field == 8'h00 &&
    desc.end_field == 8'hFC && map.start_bit == 9'h000)
    else $error("64K section fields wrong");

  lo32_fields_a: assert property (@(posedge clk) disable iff (!nrst)
    out_valid && map.sec == bpm_pkg::SEC_LO32 |-> desc.start_field == 8'hFD &&
    desc.end_field == 8'hFD)
    else $error("lower 32K fields wrong");

  hi32_fields_a: assert property (@(posedge clk) disable iff (!nrst)
    out_valid && map.sec == bpm_pkg::SEC_HI32 |-> desc.start_field == 8'hFE &&
    desc.end_field == 8'hFE)
    else $error("upper 32K fields wrong");

  bottom_lock_a: assert property (@(posedge clk) disable iff (!nrst)
    out_valid && map.sec == bpm_pkg::SEC_BOT8 |-> map.rd_bit[0] && !map.wr_bit[0] &&
    desc.start_field == 8'hFF && desc.end_field == 8'h06)
    else $error("bottom 8K lock bits wrong");

  top_lock_a: assert property (@(posedge clk) disable iff (!nrst)
    out_valid && map.sec == bpm_pkg::SEC_TOP8 |-> map.rd_bit[0] && !map.wr_bit[0] &&
    desc.start_field == 8'h07 && desc.end_field == 8'h0E)
    else $error("top 8K lock bits wrong");

  top_order_a: assert property (@(posedge clk) disable iff (!nrst)
    sample && in_range && arr_size - a_ext <= bpm_pkg::SIZE_32K |=>
    map.sec == bpm_pkg::SEC_TOP8 && desc.type_num == 8'h02)
    else $error("top 8K not its own section");

  block_pair_a: assert property (@(posedge clk) disable iff (!nrst)
    sample && sel_sec == bpm_pkg::SEC_TOP8 |=> map.wr_bit == map.start_bit +
    {6'h00, $past(addr[bpm_pkg::K_MSB:bpm_pkg::K_LSB]), 1'b0})
    else $error("top 8K block bit wrong");

endmodule

// *** bpm_req_model.sv ***
/*
  Requesting command logic beside the bit mapper.
  Assumes the bench sets go, a and m at the falling clock edge.
*/
`timescale 1ns/1ns
module bpm_req_model (
  // Clock.
  input wire logic clk,
  // From the bench.
  input wire logic go,
  input wire logic [23:0] a,
  input wire logic [3:0] m,
  // To the mapper.
  output logic sample,
  output logic [23:0] addr,
  output logic [3:0] dens_m
);
  logic [23:0] junk = 24'hA5A5A5;
  // Idle lines carry a changing pattern, never the last request.
  always @(posedge clk) junk <= ~junk;
  assign sample = go;
  assign addr = go ? a : junk;
  assign dens_m = go ? m : junk[3:0];
endmodule

// *** testbench.sv ***
/*
  Self-checking bench of the bit mapper.
  Assumes the mapper answers one clock after each taken sample.
*/
`timescale 1ns/1ns
module testbench;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic go = 1'b0;
  logic [23:0] a = 24'h000000;
  logic [3:0] m = 4'h5;
  logic sample;
  logic [23:0] addr;
  logic [3:0] dens_m;
  logic out_valid;
  logic out_err;
  bpm_pkg::bpm_map_t map;
  bpm_pkg::bpm_map_t em;
  bpm_pkg::bpm_desc_t desc;
  bpm_pkg::bpm_desc_t ed;
  logic ee;
  logic pend = 1'b0;
  logic [32:0] t;
  logic [23:0] ta;
  int bad_count = 0;
  int checked = 0;
  int cyc = 0;
  always #50 clk = ~clk;
  bpm_req_model req_u (.clk(clk), .go(go), .a(a), .m(m), .sample(sample), .addr(addr),
    .dens_m(dens_m));
  bpm_mapper dut_u (.clk(clk), .nrst(nrst), .sample(sample), .addr(addr), .dens_m(dens_m),
    .out_valid(out_valid), .out_err(out_err), .map(map), .desc(desc));
  task complete_run;
    $display("Mismatches %0d, checks %0d", bad_count, checked);
    if (bad_count == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task chk_flag(input logic g, input logic e);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %0t flag %b exp %b", $time, g, e);
    end
  endtask
  task chk_map(input bpm_pkg::bpm_map_t g, input bpm_pkg::bpm_map_t e);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %0t map %h exp %h", $time, g, e);
    end
  endtask
  task chk_desc(input bpm_pkg::bpm_desc_t g, input bpm_pkg::bpm_desc_t e);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %0t desc %h exp %h", $time, g, e);
    end
  endtask
  task plan(input logic [23:0] x, input logic [3:0] k);
    logic [32:0] tot;
    logic [8:0] b;
    logic [8:0] w;
    tot = 33'h1 << (k + 5'h10);
    b = (9'h1 << k) + 9'h1;
    w = {6'h0, x[14:13], 1'b0};
    em = '0;
    ed = '0;
    ee = 1'b0;
    if (k < 4'h4 || k > 4'h8 || {9'h0, x} >= tot) ee = 1'b1;
    else if (x < 24'h008000) begin
      em = '{bpm_pkg::SEC_BOT8, b - 9'h1 + w, b + w, 1'b1, b - 9'h1, b + 9'h6, 9'h4, 8'h4E};
      ed = '{8'h02, 8'h02, 8'hFF, 8'h06};
    end else if (x < 24'h010000) begin
      em = '{bpm_pkg::SEC_LO32, b - 9'h3, b - 9'h3, 1'b0, b - 9'h3, b - 9'h3, 9'h1, 8'h50};
      ed = '{8'h03, 8'h00, 8'hFD, 8'hFD};
    end else if ({9'h0, x} < tot - bpm_pkg::SIZE_64K) begin
      w = {1'b0, x[23:16]} - 9'h1;
      em = '{bpm_pkg::SEC_MID64, w, w, 1'b0, 9'h0, b - 9'h4, b - 9'h3, 8'h52};
      ed = '{8'h04, {4'h0, k}, 8'h00, 8'hFC};
    end else if ({9'h0, x} < tot - bpm_pkg::SIZE_32K) begin
      em = '{bpm_pkg::SEC_HI32, b - 9'h2, b - 9'h2, 1'b0, b - 9'h2, b - 9'h2, 9'h1, 8'h50};
      ed = '{8'h03, 8'h00, 8'hFE, 8'hFE};
    end else begin
      w = b + 9'h7 + w;
      em = '{bpm_pkg::SEC_TOP8, w, w + 9'h1, 1'b1, b + 9'h7, b + 9'hE, 9'h4, 8'h4E};
      ed = '{8'h02, 8'h02, 8'h07, 8'h0E};
    end
  endtask
  task step(input logic g, input logic [23:0] x, input logic [3:0] k);
    @(negedge clk);
    if (pend) begin
      chk_flag(out_valid, 1'b1);
      chk_flag(out_err, ee);
      chk_map(map, em);
      chk_desc(desc, ed);
    end
    go = g;
    a = x;
    m = k;
    if (g) begin
      plan(x, k);
      pend = 1'b1;
    end
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      bad_count++;
      complete_run();
    end
  end
  initial begin
    repeat (3) @(negedge clk);
    chk_map(map, '0);
    nrst = 1'b1;
    step(1'b0, 24'h0, 4'h5);
    chk_flag(out_valid, 1'b0);
    step(1'b1, 24'h00A000, 4'h5);
    for (int k = 4; k <= 8; k++) begin
      t = 33'h1 << (k + 16);
      for (int i = 0; i < 11; i++) begin
        case (i)
          0: ta = 24'h000000;
          1: ta = 24'h006000;
          2: ta = 24'h008000;
          3: ta = 24'h010000;
          4: ta = 24'(t - 33'h10001);
          5: ta = 24'(t - 33'h10000);
          6: ta = 24'(t - 33'h8000);
          7: ta = 24'(t - 33'h6000);
          8: ta = 24'(t - 33'h2000);
          9: ta = 24'(t - 33'h1);
          default: ta = 24'(t);
        endcase
        step(1'b1, ta, k[3:0]);
      end
    end
    step(1'b1, 24'h0, 4'h3);
    step(1'b1, 24'h0, 4'h9);
    step(1'b1, 24'h100000, 4'h4);
    step(1'b1, 24'h00E000, 4'h7);
    repeat (3) step(1'b0, 24'h0, 4'h5);
    nrst = 1'b0;
    pend = 1'b0;
    step(1'b0, 24'h0, 4'h5);
    chk_flag(out_valid, 1'b0);
    chk_map(map, '0);
    chk_desc(desc, '0);
    chk_flag(out_err, 1'b0);
    nrst = 1'b1;
    step(1'b1, 24'h00C000, 4'h6);
    step(1'b0, 24'h0, 4'h6);
    complete_run();
  end
endmodule
